// ### errm_pkg.sv
// Constants, field layouts and register types of the expanded register bank.
// Summary of operation
// - Stack lives ..R239, pointer at R255.
// - R254 is plain storage, stack ignores it.
// - Timer extra control bits 4..0 read ones.
// - Reloads and captures: clear on power-on, kept on recovery.
// - Stop recovery config keeps bits 6..1, clears bit 0, sets flag bit 7.
// - Timer extra control resets 1F, bit 5 kept.
// - Timer16 control bits 5..2 kept on recovery.
// - Shared timer control bits 5,4 kept on recovery.
// - Timer8 control bits 5..1 kept on recovery.
package errm_pkg;

    // Word indices inside each bank; byte address is base plus four times index.
    localparam logic [3:0] IDX_TIMER8_CONTROL       = 4'h0;
    localparam logic [3:0] IDX_TIMER_SHARED_CONTROL = 4'h1;
    localparam logic [3:0] IDX_TIMER16_CONTROL      = 4'h2;
    localparam logic [3:0] IDX_TIMER_EXTRA_CONTROL  = 4'h3;
    localparam logic [3:0] IDX_TIMER8_RELOAD_LOW    = 4'h4;
    localparam logic [3:0] IDX_TIMER8_RELOAD_HIGH   = 4'h5;
    localparam logic [3:0] IDX_TIMER16_RELOAD_LOW   = 4'h6;
    localparam logic [3:0] IDX_TIMER16_RELOAD_HIGH  = 4'h7;
    localparam logic [3:0] IDX_CAPTURE16_LOW        = 4'h8;
    localparam logic [3:0] IDX_CAPTURE16_HIGH       = 4'h9;
    localparam logic [3:0] IDX_CAPTURE8_LOW         = 4'hA;
    localparam logic [3:0] IDX_CAPTURE8_HIGH        = 4'hB;
    localparam logic [3:0] IDX_PORT0_DATA           = 4'h0;
    localparam logic [3:0] IDX_PORT1_DATA           = 4'h1;
    localparam logic [3:0] IDX_PORT2_DATA           = 4'h2;
    localparam logic [3:0] IDX_PORT3_DATA           = 4'h3;
    localparam logic [3:0] IDX_PORT_OUTPUT_CONFIG   = 4'h0;
    localparam logic [3:0] IDX_STOP_RECOVERY_CONFIG = 4'hB;

    // Bank selection by word address bits 9:4.
    localparam logic [5:0] BANK_TIMER = 6'h00;
    localparam logic [5:0] BANK_PORT  = 6'h01;
    localparam logic [5:0] BANK_CFG   = 6'h02;
    // Register file occupies word addresses 0x100..0x1FF.
    localparam logic [1:0] BANK_FILE_TOP = 2'h1;

    localparam logic [7:0] REG_STACK_LOW  = 8'h04;
    localparam logic [7:0] REG_STACK_HIGH = 8'hEF;
    localparam logic [7:0] REG_SP_UPPER   = 8'hFE;
    localparam logic [7:0] REG_SP_LOW     = 8'hFF;

    // Power-on reset values.
    localparam logic [7:0] RST_ZERO        = 8'h00;
    localparam logic [7:0] RST_EXTRA_CTL   = 8'h1F;
    localparam logic [7:0] RST_PORT_CFG    = 8'hFE;
    localparam logic [7:0] RST_STOP_CFG    = 8'h20;

    // Bits that survive a stop-mode recovery.
    localparam logic [7:0] KEEP_TIMER8_CTL = 8'h3E;
    localparam logic [7:0] KEEP_SHARED_CTL = 8'h30;
    localparam logic [7:0] KEEP_T16_CTL    = 8'h3C;
    localparam logic [7:0] KEEP_EXTRA_CTL  = 8'h20;
    localparam logic [7:0] KEEP_STOP_CFG   = 8'hFE;

    localparam logic [7:0] EXTRA_RO_ONES   = 8'h1F;
    localparam logic [7:0] STOP_FLAG_BIT   = 8'h80;

    typedef struct packed {
        logic [7:0] timer8_control;
        logic [7:0] timer_shared_control;
        logic [7:0] timer16_control;
        logic [7:0] timer_extra_control;
        logic [7:0] timer8_reload_low;
        logic [7:0] timer8_reload_high;
        logic [7:0] timer16_reload_low;
        logic [7:0] timer16_reload_high;
        logic [7:0] capture16_low;
        logic [7:0] capture16_high;
        logic [7:0] capture8_low;
        logic [7:0] capture8_high;
        logic [7:0] port0_data;
        logic [7:0] port1_data;
        logic [7:0] port2_data;
        logic [7:0] port3_data;
        logic [7:0] port_output_config;
        logic [7:0] stop_recovery_config;
    } errm_regs_t;

endpackage

// ### errm_bank.sv
// Expanded register bank with APB slave, internal stack and two reset classes.
`timescale 1ns/1ns
module errm_bank (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                stop_recover,
    input  wire logic                stk_push,
    input  wire logic                stk_pop,
    input  wire logic [7:0]          stk_wdata,
    output logic      [7:0]          stk_rdata,
    output logic                     stk_fault,
    output errm_pkg::errm_regs_t     regs
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        errm_pkg::errm_regs_t regs;
        logic [7:0]           sp_upper;
        logic [7:0]           sp_low;
        logic [31:0]          prdata;
        logic                 pready;
        logic                 pslverr;
        logic [7:0]           stk_rdata;
        logic                 stk_fault;
    } errm_state_t;

    errm_state_t state_r;
    errm_state_t state_nxt;

    // General register file; only the stack window is backed by storage.
    logic [7:0] gpr_mem [256];

    logic        setup;
    logic        access;
    logic [9:0]  word;
    logic [3:0]  idx;
    logic [7:0]  fidx;
    logic        in_file;
    logic        in_stack;
    logic        mapped;
    logic [7:0]  wbyte;
    logic [7:0]  rbyte;
    logic [7:0]  sp_dec;
    logic        push_ok;
    logic        pop_ok;
    logic        mem_we;
    logic [7:0]  mem_addr;
    logic [7:0]  mem_wdata;

    assign setup    = psel & ~penable;
    assign access   = psel & penable & state_r.pready;
    assign word     = paddr[11:2];
    assign idx      = word[3:0];
    assign fidx     = word[7:0];
    assign in_file  = (word[9:8] == errm_pkg::BANK_FILE_TOP);
    assign in_stack = in_file && fidx >= errm_pkg::REG_STACK_LOW
                      && fidx <= errm_pkg::REG_STACK_HIGH;
    assign wbyte    = pwdata[7:0];
    assign sp_dec   = state_r.sp_low - 8'h01;

    // Push pre-decrements, pop post-increments; both stay inside the window.
    assign push_ok = stk_push && sp_dec >= errm_pkg::REG_STACK_LOW
                     && sp_dec <= errm_pkg::REG_STACK_HIGH;
    assign pop_ok  = stk_pop && !stk_push
                     && state_r.sp_low >= errm_pkg::REG_STACK_LOW
                     && state_r.sp_low <= errm_pkg::REG_STACK_HIGH;

    ////////////////////////////////////////////////////////////////////////
    // Address decode and read mux.
    always_comb begin
        mapped = 1'b0;
        rbyte  = 8'h00;
        if (paddr[1:0] != 2'h0) begin
            mapped = 1'b0;
        end else if (in_file) begin
            if (in_stack) begin
                mapped = 1'b1;
                rbyte  = gpr_mem[fidx];
            end else if (fidx == errm_pkg::REG_SP_UPPER) begin
                mapped = 1'b1;
                rbyte  = state_r.sp_upper;
            end else if (fidx == errm_pkg::REG_SP_LOW) begin
                mapped = 1'b1;
                rbyte  = state_r.sp_low;
            end
        end else if (word[9:4] == errm_pkg::BANK_TIMER) begin
            mapped = 1'b1;
            unique case (idx)
                errm_pkg::IDX_TIMER8_CONTROL:
                    rbyte = state_r.regs.timer8_control;
                errm_pkg::IDX_TIMER_SHARED_CONTROL:
                    rbyte = state_r.regs.timer_shared_control;
                errm_pkg::IDX_TIMER16_CONTROL:
                    rbyte = state_r.regs.timer16_control;
                errm_pkg::IDX_TIMER_EXTRA_CONTROL:
                    rbyte = state_r.regs.timer_extra_control
                            | errm_pkg::EXTRA_RO_ONES;
                errm_pkg::IDX_TIMER8_RELOAD_LOW:
                    rbyte = state_r.regs.timer8_reload_low;
                errm_pkg::IDX_TIMER8_RELOAD_HIGH:
                    rbyte = state_r.regs.timer8_reload_high;
                errm_pkg::IDX_TIMER16_RELOAD_LOW:
                    rbyte = state_r.regs.timer16_reload_low;
                errm_pkg::IDX_TIMER16_RELOAD_HIGH:
                    rbyte = state_r.regs.timer16_reload_high;
                errm_pkg::IDX_CAPTURE16_LOW:
                    rbyte = state_r.regs.capture16_low;
                errm_pkg::IDX_CAPTURE16_HIGH:
                    rbyte = state_r.regs.capture16_high;
                errm_pkg::IDX_CAPTURE8_LOW:
                    rbyte = state_r.regs.capture8_low;
                errm_pkg::IDX_CAPTURE8_HIGH:
                    rbyte = state_r.regs.capture8_high;
                default:
                    mapped = 1'b0;
            endcase
        end else if (word[9:4] == errm_pkg::BANK_PORT) begin
            mapped = 1'b1;
            unique case (idx)
                errm_pkg::IDX_PORT0_DATA: rbyte = state_r.regs.port0_data;
                errm_pkg::IDX_PORT1_DATA: rbyte = state_r.regs.port1_data;
                errm_pkg::IDX_PORT2_DATA: rbyte = state_r.regs.port2_data;
                errm_pkg::IDX_PORT3_DATA: rbyte = state_r.regs.port3_data;
                default:                  mapped = 1'b0;
            endcase
        end else if (word[9:4] == errm_pkg::BANK_CFG) begin
            mapped = 1'b1;
            unique case (idx)
                errm_pkg::IDX_PORT_OUTPUT_CONFIG:
                    rbyte = state_r.regs.port_output_config;
                // Only the recovery flag is readable; the rest is write-only.
                errm_pkg::IDX_STOP_RECOVERY_CONFIG:
                    rbyte = state_r.regs.stop_recovery_config
                            & errm_pkg::STOP_FLAG_BIT;
                default:
                    mapped = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic: APB writes, stack operations, then recovery on top.
    always_comb begin
        state_nxt = state_r;
        state_nxt.pready = setup;
        if (setup) begin
            state_nxt.prdata  = {24'h000000, pwrite ? 8'h00 : rbyte};
            state_nxt.pslverr = ~mapped;
        end else if (access) begin
            state_nxt.prdata  = 32'h00000000;
            state_nxt.pslverr = 1'b0;
        end
        if (access && pwrite && mapped && !in_file) begin
            if (word[9:4] == errm_pkg::BANK_TIMER) begin
                unique case (idx)
                    errm_pkg::IDX_TIMER8_CONTROL:
                        state_nxt.regs.timer8_control = wbyte;
                    errm_pkg::IDX_TIMER_SHARED_CONTROL:
                        state_nxt.regs.timer_shared_control = wbyte;
                    errm_pkg::IDX_TIMER16_CONTROL:
                        state_nxt.regs.timer16_control = wbyte;
                    errm_pkg::IDX_TIMER_EXTRA_CONTROL:
                        state_nxt.regs.timer_extra_control =
                            (wbyte & ~errm_pkg::EXTRA_RO_ONES)
                            | errm_pkg::EXTRA_RO_ONES;
                    errm_pkg::IDX_TIMER8_RELOAD_LOW:
                        state_nxt.regs.timer8_reload_low = wbyte;
                    errm_pkg::IDX_TIMER8_RELOAD_HIGH:
                        state_nxt.regs.timer8_reload_high = wbyte;
                    errm_pkg::IDX_TIMER16_RELOAD_LOW:
                        state_nxt.regs.timer16_reload_low = wbyte;
                    errm_pkg::IDX_TIMER16_RELOAD_HIGH:
                        state_nxt.regs.timer16_reload_high = wbyte;
                    errm_pkg::IDX_CAPTURE16_LOW:
                        state_nxt.regs.capture16_low = wbyte;
                    errm_pkg::IDX_CAPTURE16_HIGH:
                        state_nxt.regs.capture16_high = wbyte;
                    errm_pkg::IDX_CAPTURE8_LOW:
                        state_nxt.regs.capture8_low = wbyte;
                    default:
                        state_nxt.regs.capture8_high = wbyte;
                endcase
            end else if (word[9:4] == errm_pkg::BANK_PORT) begin
                unique case (idx)
                    errm_pkg::IDX_PORT0_DATA:
                        state_nxt.regs.port0_data = wbyte;
                    errm_pkg::IDX_PORT1_DATA:
                        state_nxt.regs.port1_data = wbyte;
                    errm_pkg::IDX_PORT2_DATA:
                        state_nxt.regs.port2_data = wbyte;
                    default:
                        state_nxt.regs.port3_data = wbyte;
                endcase
            end else if (idx == errm_pkg::IDX_PORT_OUTPUT_CONFIG) begin
                state_nxt.regs.port_output_config = wbyte;
            end else begin
                // The recovery flag is owned by hardware.
                state_nxt.regs.stop_recovery_config =
                    (wbyte & ~errm_pkg::STOP_FLAG_BIT)
                    | (state_r.regs.stop_recovery_config
                       & errm_pkg::STOP_FLAG_BIT);
            end
        end
        if (access && pwrite && in_file) begin
            if (fidx == errm_pkg::REG_SP_UPPER) begin
                state_nxt.sp_upper = wbyte;
            end else if (fidx == errm_pkg::REG_SP_LOW) begin
                state_nxt.sp_low = wbyte;
            end
        end
        // A stack operation wins over a software write of the pointer.
        state_nxt.stk_fault = (stk_push && !push_ok)
                              || (stk_pop && !stk_push && !pop_ok);
        if (push_ok) begin
            state_nxt.sp_low = sp_dec;
        end else if (pop_ok) begin
            state_nxt.stk_rdata = gpr_mem[state_r.sp_low];
            state_nxt.sp_low    = state_r.sp_low + 8'h01;
        end
        if (stop_recover) begin
            state_nxt.regs.timer8_control =
                state_r.regs.timer8_control
                & errm_pkg::KEEP_TIMER8_CTL;
            state_nxt.regs.timer_shared_control =
                state_r.regs.timer_shared_control
                & errm_pkg::KEEP_SHARED_CTL;
            state_nxt.regs.timer16_control =
                state_r.regs.timer16_control
                & errm_pkg::KEEP_T16_CTL;
            state_nxt.regs.timer_extra_control =
                (state_r.regs.timer_extra_control
                 & errm_pkg::KEEP_EXTRA_CTL)
                | (errm_pkg::RST_EXTRA_CTL
                   & ~errm_pkg::KEEP_EXTRA_CTL);
            // Reloads and captures keep everything; an APB write to them in the same cycle is dropped.
            state_nxt.regs.timer8_reload_low =
                state_r.regs.timer8_reload_low;
            state_nxt.regs.timer8_reload_high =
                state_r.regs.timer8_reload_high;
            state_nxt.regs.timer16_reload_low =
                state_r.regs.timer16_reload_low;
            state_nxt.regs.timer16_reload_high =
                state_r.regs.timer16_reload_high;
            state_nxt.regs.capture16_low  = state_r.regs.capture16_low;
            state_nxt.regs.capture16_high = state_r.regs.capture16_high;
            state_nxt.regs.capture8_low   = state_r.regs.capture8_low;
            state_nxt.regs.capture8_high  = state_r.regs.capture8_high;
            state_nxt.regs.stop_recovery_config =
                (state_r.regs.stop_recovery_config
                 & errm_pkg::KEEP_STOP_CFG)
                | errm_pkg::STOP_FLAG_BIT;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power-on reset gives every register outside the file storage its full reset value.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= '0;
            state_r.regs.timer_extra_control  <= errm_pkg::RST_EXTRA_CTL;
            state_r.regs.port_output_config   <= errm_pkg::RST_PORT_CFG;
            state_r.regs.stop_recovery_config <= errm_pkg::RST_STOP_CFG;
        end else begin
            state_r <= state_nxt;
        end
    end

    // One write port: a push takes it, otherwise a software write does.
    always_comb begin
        mem_we    = 1'b0;
        mem_addr  = fidx;
        mem_wdata = wbyte;
        if (push_ok) begin
            mem_we    = 1'b1;
            mem_addr  = sp_dec;
            mem_wdata = stk_wdata;
        end else if (access && pwrite && in_stack) begin
            mem_we = 1'b1;
        end
    end

    // Storage is not reset, like the register file it models.
    always_ff @(posedge pclk) begin
        if (mem_we) begin
            gpr_mem[mem_addr] <= mem_wdata;
        end
    end

    assign prdata    = state_r.prdata;
    assign pready    = state_r.pready;
    assign pslverr   = state_r.pslverr;
    assign stk_rdata = state_r.stk_rdata;
    assign stk_fault = state_r.stk_fault;
    assign regs      = state_r.regs;

endmodule

// ### errm_bank_props.sv
// Concurrent checks on the ports of the expanded register bank.
`timescale 1ns/1ns
module errm_bank_props (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [11:0]          paddr,
    input wire logic [31:0]          pwdata,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic                 stop_recover,
    input wire logic                 stk_push,
    input wire logic                 stk_pop,
    input wire logic [7:0]           stk_wdata,
    input wire logic [7:0]           stk_rdata,
    input wire logic                 stk_fault,
    input wire errm_pkg::errm_regs_t regs
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    extra_ones_a: assert property (
        regs.timer_extra_control[4:0] == 5'h1F)
        else $error("extra control low bits not ones");
    extra_read_a: assert property (
        psel && !penable && !pwrite && paddr == 12'h00C
        |=> pready && prdata[4:0] == 5'h1F)
        else $error("extra control read lost low ones");
    rec_timer8_a: assert property (
        stop_recover |=> regs.timer8_control ==
        ($past(regs.timer8_control) & 8'h3E))
        else $error("timer8 control wrong after recovery");
    rec_shared_a: assert property (
        stop_recover |=> regs.timer_shared_control ==
        ($past(regs.timer_shared_control) & 8'h30))
        else $error("shared control wrong after recovery");
    rec_timer16_a: assert property (
        stop_recover |=> regs.timer16_control ==
        ($past(regs.timer16_control) & 8'h3C))
        else $error("timer16 control wrong after recovery");
    rec_extra_a: assert property (
        stop_recover |=> regs.timer_extra_control ==
        (($past(regs.timer_extra_control) & 8'h20) | 8'h1F))
        else $error("extra control wrong after recovery");
    rec_stopcfg_a: assert property (
        stop_recover |=> regs.stop_recovery_config ==
        (($past(regs.stop_recovery_config) & 8'hFE) | 8'h80))
        else $error("stop config wrong after recovery");
    rec_hold_a: assert property (
        stop_recover && !(psel && penable) |=> $stable({
        regs.timer8_reload_low, regs.timer8_reload_high,
        regs.timer16_reload_low, regs.timer16_reload_high,
        regs.capture16_low, regs.capture16_high,
        regs.capture8_low, regs.capture8_high}))
        else $error("reload or capture changed by recovery");
    por_values_a: assert property (
        $rose(presetn) |->
        regs == 144'h0000001F000000000000000000000000FE20)
        else $error("register values wrong after power-on");
    fault_cause_a: assert property (
        stk_fault |-> $past(stk_push) || $past(stk_pop))
        else $error("stack fault without a stack request");
endmodule

bind errm_bank errm_bank_props u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stop_recover(stop_recover),
    .stk_push(stk_push), .stk_pop(stk_pop), .stk_wdata(stk_wdata),
    .stk_rdata(stk_rdata), .stk_fault(stk_fault), .regs(regs));

// ### errm_bank_bench.sv
// Self-checking bench for the expanded register bank.
`timescale 1ns/1ns
module errm_bank_bench;
    logic                 pclk = 1'b0;
    logic                 presetn = 1'b0;
    logic                 psel = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite = 1'b0;
    logic [11:0]          paddr = 12'h000;
    logic [31:0]          pwdata = 32'h0;
    logic                 stop_recover = 1'b0;
    logic                 stk_push = 1'b0;
    logic                 stk_pop = 1'b0;
    logic [7:0]           stk_wdata = 8'h00;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic [7:0]           stk_rdata;
    logic                 stk_fault;
    errm_pkg::errm_regs_t regs;
    errm_pkg::errm_regs_t m;
    logic [31:0]          rd_v;
    logic                 err_v;
    int                   num_errors = 0;
    int                   n_checks = 0;
    int                   seed_v;

    errm_bank uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .stop_recover(stop_recover),
        .stk_push(stk_push), .stk_pop(stk_pop), .stk_wdata(stk_wdata),
        .stk_rdata(stk_rdata), .stk_fault(stk_fault), .regs(regs));

    always #25 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [143:0] seen, input logic [143:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Byte slot of the model struct for a bank address, or -1 if unmapped.
    function automatic int slot(input logic [11:0] ad);
        if (ad[1:0] != 2'h0) return -1;
        if (ad[11:6] == 6'h00 && ad[5:2] < 4'hC) return int'(ad[5:2]);
        if (ad[11:4] == 8'h04) return 12 + int'(ad[3:2]);
        if (ad == 12'h080) return 16;
        if (ad == 12'h0AC) return 17;
        return -1;
    endfunction

    function automatic logic [31:0] exp_rd(input logic [11:0] ad);
        int         k;
        logic [7:0] v;
        k = slot(ad);
        if (k < 0) return 32'h0;
        v = m[8*(17-k) +: 8];
        if (k == 17) v = v & 8'h80;
        return {24'h0, v};
    endfunction

    // The answer is taken at the rising edge where pready is seen high;
    // only the watchdog ends a wait that never gets one.
    task automatic apb(input logic w, input logic [11:0] ad,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        check(pready, 1'b1);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask

    task automatic bank(input logic w, input logic [11:0] ad,
                        input logic [7:0] d);
        int         k;
        logic [7:0] v;
        k = slot(ad);
        apb(w, ad, {24'h0, d});
        check(err_v, k < 0);
        if (!w) check(rd_v, exp_rd(ad));
        if (w && k >= 0) begin
            v = d;
            if (k == 3) v = (d & 8'hE0) | 8'h1F;
            if (k == 17) v = (m.stop_recovery_config & 8'h80) | (d & 8'h7F);
            m[8*(17-k) +: 8] = v;
        end
        check(regs, m);
    endtask

    task automatic recover();
        @(posedge pclk);
        stop_recover <= 1'b1;
        @(posedge pclk);
        stop_recover <= 1'b0;
        @(negedge pclk);
        m.timer8_control &= 8'h3E;
        m.timer_shared_control &= 8'h30;
        m.timer16_control &= 8'h3C;
        m.timer_extra_control = (m.timer_extra_control & 8'h20) | 8'h1F;
        m.stop_recovery_config = (m.stop_recovery_config & 8'hFE) | 8'h80;
        check(regs, m);
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        m = 144'h0000001F000000000000000000000000FE20;
        check(regs, m);
    endtask

    task automatic stk(input logic pu, input logic po, input logic [7:0] d,
                       input logic f, input logic [7:0] r);
        @(posedge pclk);
        stk_push <= pu;
        stk_pop <= po;
        stk_wdata <= d;
        @(posedge pclk);
        stk_push <= 1'b0;
        stk_pop <= 1'b0;
        @(negedge pclk);
        check(stk_fault, f);
        if (po && !f) check(stk_rdata, r);
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        close_out();
    end

    initial begin
        seed_v = $urandom(32'h5ca9ef35);
        do_reset();
        for (int i = 0; i < 44; i++) bank(1'b0, 12'(i * 4), 8'h00);
        for (int i = 0; i < 12; i++) bank(1'b1, 12'(i * 4), 8'hFF);
        bank(1'b1, 12'h0AC, 8'hFF);
        bank(1'b1, 12'h001, 8'h33);
        recover();
        bank(1'b1, 12'h00C, 8'h00);
        bank(1'b0, 12'h0AC, 8'h00);
        repeat (60) begin
            bank(1'b1, {4'h0, 6'($urandom_range(0, 43)), 2'b00}, 8'($urandom));
            if ($urandom_range(0, 3) == 0) recover();
            bank(1'b0, {4'h0, 6'($urandom_range(0, 43)), 2'b00}, 8'h00);
        end
        @(posedge pclk);
        do_reset();
        apb(1'b1, 12'h7FC, 32'hF0);
        apb(1'b1, 12'h7F8, 32'h5A);
        stk(1'b1, 1'b0, 8'hAA, 1'b0, 8'h00);
        stk(1'b1, 1'b0, 8'h55, 1'b0, 8'h00);
        apb(1'b0, 12'h7FC, 32'h0);
        check(rd_v, 32'hEE);
        apb(1'b0, 12'h7BC, 32'h0);
        check(rd_v, 32'hAA);
        stk(1'b0, 1'b1, 8'h00, 1'b0, 8'h55);
        stk(1'b0, 1'b1, 8'h00, 1'b0, 8'hAA);
        stk(1'b0, 1'b1, 8'h00, 1'b1, 8'h00);
        apb(1'b1, 12'h7FC, 32'h05);
        stk(1'b1, 1'b0, 8'h77, 1'b0, 8'h00);
        stk(1'b1, 1'b0, 8'h11, 1'b1, 8'h00);
        stk(1'b0, 1'b1, 8'h00, 1'b0, 8'h77);
        apb(1'b0, 12'h7F8, 32'h0);
        check(rd_v, 32'h5A);
        apb(1'b0, 12'h408, 32'h0);
        check(err_v, 1'b1);
        close_out();
    end
endmodule
